// *** cmt_pkg.sv ***
package cmt_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CMD_REQUEST   = 8'h20;
    localparam logic [7:0] OFS_TRANSFER_SEL  = 8'h24;
    localparam logic [7:0] OFS_MSG_CONTROL   = 8'h38;
    localparam logic [7:0] OFS_LOWER_LO      = 8'h3C;
    localparam logic [7:0] OFS_LOWER_HI      = 8'h40;
    localparam logic [7:0] OFS_UPPER_LO      = 8'h44;
    localparam logic [7:0] OFS_UPPER_HI      = 8'h48;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          BUSY_BIT         = 15;
    localparam int          FRESH_BIT        = 15;
    localparam int          IRQ_BIT          = 13;
    localparam int          SEND_BIT         = 8;
    localparam logic [5:0]  OBJ_NUM_RESET    = 6'h01;
    localparam int          NUM_OBJECTS      = 32;

    // ------------------------------------------------------------
    // Timing: RAM transfer takes 3 to 6 module clocks
    // ------------------------------------------------------------
    localparam int          XFER_MIN_CYC     = 3;
    localparam int          XFER_MAX_CYC     = 6;
    localparam logic [2:0]  XFER_CYCLES      = 3'(XFER_MIN_CYC + 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_MOVE = 2'b11
    } cmt_state_t;

    typedef struct packed {
        logic       dir_write;
        logic       mask_sel;
        logic       arb_sel;
        logic       control_sel;
        logic       clear_pending_select;
        logic       fresh_send_select;
        logic       lower_bytes_select;
        logic       upper_bytes_select;
    } cmt_select_t;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [31:0] lower;
        logic [31:0] upper;
    } cmt_object_t;
endpackage

// *** cmt_transfer_mask.sv ***
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
// Behaviour
// RULE1: Control select one moves control bits; zero leaves them untouched.
// RULE2: Write direction with clear-pending select one clears object pending flag.
// RULE3: Read direction, clear-pending select zero copies object pending flag to interface.
// RULE4: Read direction, clear-pending select one clears pending flag in RAM object.
// RULE5: Read-side clearing delivers flag values as they were before clearing.
// RULE6: Write direction with shared select one requests transmission of object.
// RULE7: Shared select requesting transmission overrides interface send-request bit.
// RULE8: Read direction, shared select zero copies object new-data flag to interface.
// RULE9: Read direction, shared select one clears new-data flag in RAM object.
// RULE10: Lower select and direction one move object bytes 0-3 to interface.
// RULE11: Lower select zero keeps bytes 0-3; direction zero moves interface to object.
// RULE12: Upper select and direction one move object bytes 4-7 to interface.
// RULE13: Upper select zero keeps bytes 4-7; direction zero moves interface to object.
// RULE14: Object number write starts transfer, sets busy, busy clears 3-6 clocks later.
// RULE15: Direction bit chooses the transfer direction on every transfer.
module cmt_transfer_mask (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    output logic [31:0]                avs_readdata,
    output logic                       avs_waitrequest,
    output logic                       transfer_busy,
    output logic                       send_start,
    output logic [4:0]                 send_object
);
    import cmt_pkg::*;

    // ------------------------------------------------------------
    // Object number to RAM index: 0 wraps to 32, 0x21+ fold down
    // ------------------------------------------------------------
    function automatic logic [4:0] obj_index(input logic [5:0] num);
        obj_index = num[4:0] - 5'h01;
    endfunction

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [31:0] join_halves(input logic [15:0] hi,
                                                input logic [15:0] lo);
        join_halves = {hi, lo};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cmt_object_t  msg_ram [NUM_OBJECTS];
    cmt_select_t  sel;
    cmt_state_t   state;
    logic [5:0]   object_number;
    logic [2:0]   wait_cnt;
    logic [15:0]  iface_msg_control_reg;
    logic [15:0]  iface_lower_data_reg_lo;
    logic [15:0]  iface_lower_data_reg_hi;
    logic [15:0]  iface_upper_data_reg_lo;
    logic [15:0]  iface_upper_data_reg_hi;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic        bus_req   = avs_read | avs_write;
    wire logic        wr_now    = avs_write & ~avs_waitrequest;
    wire logic        wr_crq    = wr_now & hit(avs_address, OFS_CMD_REQUEST);
    wire logic        wr_sel    = wr_now & hit(avs_address, OFS_TRANSFER_SEL);
    wire logic        wr_ctl    = wr_now & hit(avs_address, OFS_MSG_CONTROL);
    wire logic        wr_llo    = wr_now & hit(avs_address, OFS_LOWER_LO);
    wire logic        wr_lhi    = wr_now & hit(avs_address, OFS_LOWER_HI);
    wire logic        wr_ulo    = wr_now & hit(avs_address, OFS_UPPER_LO);
    wire logic        wr_uhi    = wr_now & hit(avs_address, OFS_UPPER_HI);
    wire logic [15:0] wd16      = avs_writedata[15:0];

    logic [31:0] read_mux;
    always_comb begin
        read_mux = 32'h0000_0000;
        case (avs_address)
            OFS_CMD_REQUEST: begin
                read_mux[BUSY_BIT] = transfer_busy;
                read_mux[5:0]      = object_number;
            end
            OFS_TRANSFER_SEL: read_mux[7:0]  = sel;
            OFS_MSG_CONTROL:  read_mux[15:0] = iface_msg_control_reg;
            OFS_LOWER_LO:     read_mux[15:0] = iface_lower_data_reg_lo;
            OFS_LOWER_HI:     read_mux[15:0] = iface_lower_data_reg_hi;
            OFS_UPPER_LO:     read_mux[15:0] = iface_upper_data_reg_lo;
            OFS_UPPER_HI:     read_mux[15:0] = iface_upper_data_reg_hi;
            default:          read_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // One wait cycle per access; data is registered in that cycle
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read & avs_waitrequest) begin
                avs_readdata <= read_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Transfer sequencing
    // ------------------------------------------------------------
    // A new object number while busy is dropped, so the pending
    // transfer cannot be redirected half way.
    wire logic       start    = wr_crq & ~transfer_busy;
    wire logic       move     = (state == ST_MOVE);
    wire logic [4:0] idx      = obj_index(object_number);
    wire cmt_object_t obj     = msg_ram[idx];
    // Direction one writes control and flags into the object but brings the
    // data bytes back out, so new data plus control takes two transfers.
    wire logic       to_ram   = sel.dir_write;                  // RULE15
    // The zero-count wait cycle and the move state account for two transfer cycles
    localparam logic [2:0] WAIT_LOAD = XFER_CYCLES - 3'h2;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state         <= ST_IDLE;
            wait_cnt      <= 3'h0;
            transfer_busy <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state         <= ST_WAIT;           // RULE14
                        transfer_busy <= 1'b1;              // RULE14
                        wait_cnt      <= WAIT_LOAD;
                    end
                end
                ST_WAIT: begin
                    if (wait_cnt == 3'h0) begin
                        state <= ST_MOVE;
                    end else begin
                        wait_cnt <= wait_cnt - 3'h1;
                    end
                end
                ST_MOVE: begin
                    state         <= ST_IDLE;
                    transfer_busy <= 1'b0;                  // RULE14
                end
                default: begin
                    state         <= ST_IDLE;
                    transfer_busy <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Object update (toward RAM)
    // ------------------------------------------------------------
    logic [15:0] next_obj_ctrl;
    always_comb begin
        next_obj_ctrl = obj.ctrl;
        if (to_ram) begin
            if (sel.control_sel) begin
                next_obj_ctrl = iface_msg_control_reg;      // RULE1
            end
            if (sel.fresh_send_select) begin
                next_obj_ctrl[SEND_BIT] = 1'b1;             // RULE6 RULE7
            end
            if (sel.clear_pending_select) begin
                next_obj_ctrl[IRQ_BIT] = 1'b0;              // RULE2
            end
        end else begin
            if (sel.clear_pending_select) begin
                next_obj_ctrl[IRQ_BIT] = 1'b0;              // RULE4
            end
            if (sel.fresh_send_select) begin
                next_obj_ctrl[FRESH_BIT] = 1'b0;            // RULE9
            end
        end
    end

    wire logic wr_lower_obj = ~to_ram & sel.lower_bytes_select; // RULE11
    wire logic wr_upper_obj = ~to_ram & sel.upper_bytes_select; // RULE13
    wire logic rd_lower_obj = to_ram & sel.lower_bytes_select;  // RULE10
    wire logic rd_upper_obj = to_ram & sel.upper_bytes_select;  // RULE12

    // Only this transfer's selects may ask for a send. A send bit left in
    // the object by an earlier transfer would otherwise fire again on each
    // later write-direction transfer of that object.
    wire logic send_by_sel  = to_ram & sel.fresh_send_select;   // RULE6
    wire logic send_by_ctrl = to_ram & sel.control_sel
                            & iface_msg_control_reg[SEND_BIT];
    wire logic send_req     = send_by_sel | send_by_ctrl;       // RULE7

    // RAM has no reset; objects are defined by software before use
    always_ff @(posedge sys_clk) begin
        if (move) begin
            msg_ram[idx].ctrl <= next_obj_ctrl;
            if (wr_lower_obj) begin
                msg_ram[idx].lower <= join_halves(iface_lower_data_reg_hi,
                                                  iface_lower_data_reg_lo);
            end
            if (wr_upper_obj) begin
                msg_ram[idx].upper <= join_halves(iface_upper_data_reg_hi,
                                                  iface_upper_data_reg_lo);
            end
        end
    end

    // ------------------------------------------------------------
    // Send request pulse toward the transmit scheduler
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            send_start  <= 1'b0;
            send_object <= 5'h00;
        end else begin
            send_start <= move & send_req;                  // RULE6
            if (move & send_req) begin
                send_object <= idx;
            end
        end
    end

    // ------------------------------------------------------------
    // Interface registers (software side: transfer select and object number)
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sel           <= '0;
            object_number <= OBJ_NUM_RESET;
        end else begin
            if (wr_sel) begin
                sel <= cmt_select_t'(avs_writedata[7:0]);
            end
            if (start) begin
                object_number <= avs_writedata[5:0];        // RULE14
            end
        end
    end

    // ------------------------------------------------------------
    // Interface control register
    // ------------------------------------------------------------
    // RAM-to-interface loads, all taken in the move cycle
    wire logic load_ctrl  = move & ~to_ram;
    wire logic load_lower = move & rd_lower_obj;
    wire logic load_upper = move & rd_upper_obj;

    // Pre-clear flag values come from obj, sampled before the RAM write
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            iface_msg_control_reg <= 16'h0000;
        end else if (load_ctrl) begin
            if (sel.control_sel) begin
                iface_msg_control_reg <= obj.ctrl;          // RULE1
            end
            iface_msg_control_reg[IRQ_BIT]   <= obj.ctrl[IRQ_BIT];   // RULE3 RULE5
            iface_msg_control_reg[FRESH_BIT] <= obj.ctrl[FRESH_BIT]; // RULE8 RULE5
        end else if (wr_ctl) begin
            iface_msg_control_reg <= wd16;
        end
    end

    // ------------------------------------------------------------
    // Interface data registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            iface_lower_data_reg_lo <= 16'h0000;
            iface_lower_data_reg_hi <= 16'h0000;
        end else if (load_lower) begin
            iface_lower_data_reg_lo <= obj.lower[15:0];     // RULE10
            iface_lower_data_reg_hi <= obj.lower[31:16];
        end else begin
            if (wr_llo) begin
                iface_lower_data_reg_lo <= wd16;
            end
            if (wr_lhi) begin
                iface_lower_data_reg_hi <= wd16;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            iface_upper_data_reg_lo <= 16'h0000;
            iface_upper_data_reg_hi <= 16'h0000;
        end else if (load_upper) begin
            iface_upper_data_reg_lo <= obj.upper[15:0];     // RULE12
            iface_upper_data_reg_hi <= obj.upper[31:16];
        end else begin
            if (wr_ulo) begin
                iface_upper_data_reg_lo <= wd16;
            end
            if (wr_uhi) begin
                iface_upper_data_reg_hi <= wd16;
            end
        end
    end

endmodule

// *** cmt_transfer_mask_chk.sv ***
`timescale 1ns/1ps
module cmt_transfer_mask_chk
    import cmt_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        transfer_busy,
    input wire logic        send_start,
    input wire logic [4:0]  send_object
);
    // ----
    // Port relations
    // ----
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_busy_width: assert property (
        $rose(transfer_busy) |-> transfer_busy[*4] ##1 !transfer_busy)
        else $error("busy width wrong");
    a_busy_cause: assert property (
        $rose(transfer_busy) |->
        $past(avs_write && !avs_waitrequest && avs_address == OFS_CMD_REQUEST))
        else $error("busy without start");
    // Send pulse follows the end of the transfer, never during it
    a_send_after: assert property (
        send_start |-> !transfer_busy && $past(transfer_busy, 2))
        else $error("send pulse misplaced");
    a_send_pulse: assert property (
        send_start |=> !send_start)
        else $error("send pulse too long");
    a_send_hold: assert property (
        !send_start |-> $stable(send_object))
        else $error("send object moved");
    a_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no bus answer");
    a_wait_single: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address > OFS_UPPER_HI |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_sel_reserved: assert property (
        avs_read && !avs_waitrequest && avs_address == OFS_TRANSFER_SEL
        |-> avs_readdata[31:8] == 24'h0)
        else $error("select reserved bits set");
endmodule

bind cmt_transfer_mask cmt_transfer_mask_chk u_chk (
    .sys_clk         (sys_clk),
    .rstn            (rstn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .transfer_busy   (transfer_busy),
    .send_start      (send_start),
    .send_object     (send_object)
);

// *** cmt_transfer_mask_tb.sv ***
`timescale 1ns/1ps
module cmt_transfer_mask_tb;
    import cmt_pkg::*;
    logic        sys_clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
    logic        avs_waitrequest, transfer_busy, send_start;
    logic [7:0]  avs_address = 8'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic [4:0]  send_object, last_obj;
    logic [31:0] exp_q[$];
    logic [15:0] r[4];
    int          sends, num_errors = 0, checks_done = 0, cyc = 0, seed = 48, i, j;

    always #12.5 sys_clk = ~sys_clk;

    cmt_transfer_mask u_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .transfer_busy(transfer_busy), .send_start(send_start), .send_object(send_object));
    cmt_tx_sched u_tx (.sys_clk(sys_clk), .rstn(rstn), .send_start(send_start),
        .send_object(send_object), .sends(sends), .last_obj(last_obj));

    // ----
    // Checking and bus tasks
    // ----
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
        checks_done++;
        if (seen !== ex) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task end_sim;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Request held until waitrequest is sampled low, released after that edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ex);
        exp_q.push_back(ex);
        bus(1'b0, a, 32'h0);
    endtask

    // Busy is read back mid-transfer, then the bench waits for it to drop
    task xfer(input logic [7:0] sel, input logic [5:0] num);
        bus(1'b1, OFS_TRANSFER_SEL, {24'h0, sel});
        bus(1'b1, OFS_CMD_REQUEST, {26'h0, num});
        rd(OFS_CMD_REQUEST, {16'h0, 1'b1, 9'h0, num});
        for (i = 0; i < 20 && transfer_busy !== 1'b0; i++) @(posedge sys_clk);
        chk("busy", {31'h0, transfer_busy}, 32'h0);
        repeat (3) @(posedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (avs_read && !avs_waitrequest)
            chk("readdata", avs_readdata, exp_q.pop_front());
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    // ----
    // Scenarios
    // ----
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(OFS_TRANSFER_SEL, 32'h0);
        rd(OFS_CMD_REQUEST, 32'h1);
        rd(8'h4C, 32'h0);
        for (j = 0; j < 4; j++) begin
            r[j] = 16'($random(seed));
            bus(1'b1, OFS_LOWER_LO + 8'(4 * j), {16'h0, r[j]});
        end
        bus(1'b1, OFS_MSG_CONTROL, 32'hA000);
        xfer(8'h90, 6'd5);
        xfer(8'h03, 6'd5);
        for (j = 0; j < 5; j++) bus(1'b1, OFS_MSG_CONTROL + 8'(4 * j), 32'h0);
        xfer(8'h00, 6'd5);
        rd(OFS_MSG_CONTROL, 32'hA000);
        rd(OFS_LOWER_LO, 32'h0);
        bus(1'b1, OFS_MSG_CONTROL, 32'h0);
        xfer(8'h0C, 6'd5);
        rd(OFS_MSG_CONTROL, 32'hA000);
        bus(1'b1, OFS_MSG_CONTROL, 32'h0);
        xfer(8'h00, 6'd5);
        rd(OFS_MSG_CONTROL, 32'h0);
        xfer(8'h82, 6'd5);
        rd(OFS_LOWER_LO, {16'h0, r[0]});
        rd(OFS_LOWER_HI, {16'h0, r[1]});
        rd(OFS_UPPER_LO, 32'h0);
        xfer(8'h81, 6'd5);
        rd(OFS_UPPER_LO, {16'h0, r[2]});
        rd(OFS_UPPER_HI, {16'h0, r[3]});
        chk("sends", 32'(sends), 32'h0);
        bus(1'b1, OFS_MSG_CONTROL, 32'h2000);
        xfer(8'h90, 6'h21);
        xfer(8'h8C, 6'h21);
        chk("sends", 32'(sends), 32'h1);
        chk("send_obj", {27'h0, last_obj}, 32'h0);
        xfer(8'h80, 6'h21);
        chk("sends", 32'(sends), 32'h1);
        xfer(8'h00, 6'h21);
        rd(OFS_MSG_CONTROL, 32'h0);
        xfer(8'h84, 6'h00);
        chk("sends", 32'(sends), 32'h2);
        chk("send_obj", {27'h0, last_obj}, 32'h1F);
        end_sim();
    end
endmodule

// *** cmt_tx_sched.sv ***
`timescale 1ns/1ps
// Stand-in for the transmit side: counts send requests, keeps the last object
module cmt_tx_sched (
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       send_start,
    input wire logic [4:0] send_object,
    output int             sends,
    output logic [4:0]     last_obj
);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sends <= 0;
            last_obj <= 5'h0;
        end else if (send_start) begin
            sends <= sends + 1;
            last_obj <= send_object;
        end
    end
endmodule
